// *** hw/relay_pkg.sv ***
// Shared constants for the relay board control logic: command byte layout,
// reset values, line-voltage codes and watchdog timing.
// Assumes a single 10 MHz system clock domain.
package relay_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WD_TIMEOUT_S = 30;
  // Cycles without a heartbeat change before the watchdog trips
  localparam int unsigned WD_CYCLES = WD_TIMEOUT_S * CLK_HZ;
  // Arbitrary default bus address; boards set it by parameter
  localparam logic [6:0] DEV_ADDR = 7'h20;
  // Bit positions inside the command byte
  localparam int unsigned CMD_HEARTBEAT = 0;
  localparam int unsigned CMD_WHEEL_HEAT = 1;
  localparam int unsigned CMD_BENCH_HEAT = 2;
  localparam int unsigned CMD_IR_OFF = 3;
  localparam int unsigned CMD_SAMPLE_CAL = 4;
  localparam int unsigned CMD_ZERO_SPAN = 5;
  localparam int unsigned CMD_SHUTOFF = 6;
  // Safe power-up command: heaters and valves off, IR source on
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Line-voltage strap codes
  localparam logic [1:0] LINE_100 = 2'h0;
  localparam logic [1:0] LINE_115 = 2'h1;
  localparam logic [1:0] LINE_230 = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ADDR_ACK, I_DATA, I_DATA_ACK} i2c_state_t;
endpackage : relay_pkg

// *** hw/relay_watchdog.sv ***
// Relay board control: a write-only I2C target that sets heater, valve and
// IR source outputs, status indicators, and a heartbeat watchdog.
// Assumes scl, sda and the line strap come from pins, asynchronous to mclk.
`timescale 1ns/10ps
// What this block does
// - Takes command bytes over I2C and sets every relay and switch output except the wheel motor supply from them.
// - Wheel heater is one plain on/off output.
// - Bench heater energises exactly one of two elements, chosen by line voltage strap.
// - Wheel motor supply output is on whenever reset is released; no command turns it off.
// - Each calibration valve has its own output, changed only by host command or a watchdog trip.
// - IR source stays on out of reset unless the host commands it off or the watchdog trips.
// - Eight indicators show present function states; one is a spare.
// - Sample/cal indicator lit while calibration gas is selected.
// - Zero/span indicator lit while span gas is selected.
// - Shutoff indicator lit while calibration flow is open.
// - Heartbeat indicator follows the heartbeat state written by the host.
// - Heartbeat unchanged for 30 seconds forces valves, IR source and heaters off.
// - A watchdog trip leaves the wheel motor supply running.
// - From reset until the host writes or the watchdog trips, outputs hold safe defaults.
module relay_watchdog import relay_pkg::*; #(
  parameter logic [6:0] ADDR = DEV_ADDR,
  parameter int unsigned WD_LIMIT = WD_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] line_volt_sel,
  output logic wheel_heater_on,
  output logic bench_element_low_on,
  output logic bench_element_high_on,
  output logic motor_supply_on,
  output logic sample_cal_valve_on,
  output logic zero_span_valve_on,
  output logic shutoff_valve_on,
  output logic ir_source_on,
  output logic watchdog_tripped,
  output logic heartbeat_indicator,
  output logic wheel_heat_indicator,
  output logic bench_heat_indicator,
  output logic spare_indicator,
  output logic sample_cal_valve_indicator,
  output logic zero_span_valve_indicator,
  output logic shutoff_valve_indicator,
  output logic ir_source_indicator
);
  localparam int unsigned WD_W = $clog2(WD_LIMIT + 1);

  logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic sda_meta_ff, sda_sync_ff, sda_prev_ff;
  logic [1:0] line_meta_ff, line_sync_ff;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Pin inputs pass two flops; logic uses the second stage, plus a third flop on scl and sda for edge detection
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      line_meta_ff <= LINE_115;
      line_sync_ff <= LINE_115;
    end else begin
      scl_meta_ff <= scl_i;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_i;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
      line_meta_ff <= line_volt_sel;
      line_sync_ff <= line_meta_ff;
    end
  end

  assign scl_rise = scl_sync_ff && !scl_prev_ff;
  assign scl_fall = !scl_sync_ff && scl_prev_ff;
  assign bus_start = scl_sync_ff && scl_prev_ff && sda_prev_ff && !sda_sync_ff;
  assign bus_stop = scl_sync_ff && scl_prev_ff && !sda_prev_ff && sda_sync_ff;

  i2c_state_t state_ff, nxt_state;
  logic [3:0] bits_ff, nxt_bits;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] cmd_ff, nxt_cmd;
  logic ack_oe_ff, nxt_ack_oe;

  always_comb begin
    nxt_state = state_ff;
    nxt_bits = bits_ff;
    nxt_shift = shift_ff;
    nxt_cmd = cmd_ff;
    nxt_ack_oe = ack_oe_ff;
    if (bus_start) begin
      nxt_state = I_ADDR;
      nxt_bits = 4'h0;
      nxt_ack_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_state = I_IDLE;
      nxt_ack_oe = 1'b0;
    end else begin
      case (state_ff)
        I_ADDR, I_DATA: begin
          if (scl_rise && bits_ff != BITS_PER_BYTE) begin
            nxt_shift = {shift_ff[6:0], sda_sync_ff};
            nxt_bits = bits_ff + 4'h1;
          end
          if (scl_fall && bits_ff == BITS_PER_BYTE) begin
            if (state_ff == I_ADDR) begin
              // Reads are not supported, so a read address is left unanswered
              if (shift_ff[7:1] == ADDR && !shift_ff[0]) begin
                nxt_state = I_ADDR_ACK;
                nxt_ack_oe = 1'b1;
              end else begin
                nxt_state = I_IDLE;
              end
            end else begin
              nxt_cmd = shift_ff;
              nxt_state = I_DATA_ACK;
              nxt_ack_oe = 1'b1;
            end
          end
        end
        I_ADDR_ACK, I_DATA_ACK: begin
          if (scl_fall) begin
            nxt_state = I_DATA;
            nxt_bits = 4'h0;
            nxt_ack_oe = 1'b0;
          end
        end
        default: begin
          nxt_state = I_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= I_IDLE;
      bits_ff <= 4'h0;
      shift_ff <= 8'h00;
      cmd_ff <= CMD_RESET;
      ack_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bits_ff <= nxt_bits;
      shift_ff <= nxt_shift;
      cmd_ff <= nxt_cmd;
      ack_oe_ff <= nxt_ack_oe;
    end
  end

  // Watchdog: counts cycles since the last heartbeat change, saturating at the limit
  logic [WD_W-1:0] wd_cnt_ff, nxt_wd_cnt;
  logic hb_prev_ff, nxt_hb_prev;
  logic trip;

  always_comb begin
    nxt_hb_prev = cmd_ff[CMD_HEARTBEAT];
    if (cmd_ff[CMD_HEARTBEAT] != hb_prev_ff) begin
      nxt_wd_cnt = '0;
    end else if (wd_cnt_ff == WD_W'(WD_LIMIT)) begin
      nxt_wd_cnt = wd_cnt_ff;
    end else begin
      nxt_wd_cnt = wd_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_ff <= '0;
      hb_prev_ff <= CMD_RESET[CMD_HEARTBEAT];
    end else begin
      wd_cnt_ff <= nxt_wd_cnt;
      hb_prev_ff <= nxt_hb_prev;
    end
  end

  assign trip = (wd_cnt_ff == WD_W'(WD_LIMIT));

  // Output stage; every output is a flop
  logic nxt_wheel, nxt_el_low, nxt_el_high, nxt_sc, nxt_zs, nxt_so, nxt_ir, bench_on;

  always_comb begin
    nxt_wheel = cmd_ff[CMD_WHEEL_HEAT] && !trip;
    bench_on = cmd_ff[CMD_BENCH_HEAT] && !trip;
    // Undefined strap code falls back to the low-voltage element so one stays usable
    nxt_el_high = bench_on && (line_sync_ff == LINE_230);
    nxt_el_low = bench_on && (line_sync_ff != LINE_230);
    nxt_sc = cmd_ff[CMD_SAMPLE_CAL] && !trip;
    nxt_zs = cmd_ff[CMD_ZERO_SPAN] && !trip;
    nxt_so = cmd_ff[CMD_SHUTOFF] && !trip;
    nxt_ir = !cmd_ff[CMD_IR_OFF] && !trip;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      wheel_heater_on <= 1'b0;
      bench_element_low_on <= 1'b0;
      bench_element_high_on <= 1'b0;
      motor_supply_on <= 1'b0;
      sample_cal_valve_on <= 1'b0;
      zero_span_valve_on <= 1'b0;
      shutoff_valve_on <= 1'b0;
      ir_source_on <= 1'b0;
      watchdog_tripped <= 1'b0;
      heartbeat_indicator <= 1'b0;
      wheel_heat_indicator <= 1'b0;
      bench_heat_indicator <= 1'b0;
      spare_indicator <= 1'b0;
      sample_cal_valve_indicator <= 1'b0;
      zero_span_valve_indicator <= 1'b0;
      shutoff_valve_indicator <= 1'b0;
      ir_source_indicator <= 1'b0;
    end else begin
      // Open-drain: only ever pull low
      sda_o <= 1'b0;
      sda_oe <= nxt_ack_oe;
      wheel_heater_on <= nxt_wheel;
      bench_element_low_on <= nxt_el_low;
      bench_element_high_on <= nxt_el_high;
      motor_supply_on <= 1'b1;
      sample_cal_valve_on <= nxt_sc;
      zero_span_valve_on <= nxt_zs;
      shutoff_valve_on <= nxt_so;
      ir_source_on <= nxt_ir;
      watchdog_tripped <= trip;
      heartbeat_indicator <= cmd_ff[CMD_HEARTBEAT];
      wheel_heat_indicator <= nxt_wheel;
      bench_heat_indicator <= bench_on;
      spare_indicator <= 1'b0;
      sample_cal_valve_indicator <= nxt_sc;
      zero_span_valve_indicator <= nxt_zs;
      shutoff_valve_indicator <= nxt_so;
      ir_source_indicator <= nxt_ir;
    end
  end
endmodule : relay_watchdog

// *** sim/relay_watchdog_monitor.sv ***
// Concurrent checks on the relay board outputs and the heartbeat watchdog.
// Bound into relay_watchdog; sees only its ports, one clock domain.
`timescale 1ns/10ps
module relay_watchdog_monitor #(
  parameter int unsigned WD_LIMIT = 200
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wheel_heater_on,
  input wire logic bench_element_low_on,
  input wire logic bench_element_high_on,
  input wire logic motor_supply_on,
  input wire logic sample_cal_valve_on,
  input wire logic zero_span_valve_on,
  input wire logic shutoff_valve_on,
  input wire logic ir_source_on,
  input wire logic watchdog_tripped,
  input wire logic heartbeat_indicator,
  input wire logic wheel_heat_indicator,
  input wire logic bench_heat_indicator,
  input wire logic spare_indicator,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Cycles since the heartbeat indicator last moved
  logic hb_prev_ff;
  int unsigned quiet_ff, nxt_quiet;
  always_comb begin
    nxt_quiet = (heartbeat_indicator != hb_prev_ff) ? 0 : quiet_ff + 1;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hb_prev_ff <= 1'b0;
      quiet_ff <= 0;
    end else begin
      hb_prev_ff <= heartbeat_indicator;
      quiet_ff <= nxt_quiet;
    end
  end
  sequence hb_flip;
    $changed(heartbeat_indicator);
  endsequence
  chk_motor_kept_on: assert property ($past(nrst) |-> motor_supply_on)
    else $error("motor supply dropped");
  chk_bench_one_element: assert property (!(bench_element_low_on && bench_element_high_on))
    else $error("both bench elements on");
  chk_bench_ind_match: assert property (bench_heat_indicator == (bench_element_low_on || bench_element_high_on))
    else $error("bench indicator wrong");
  chk_wheel_ind_match: assert property (wheel_heat_indicator == wheel_heater_on)
    else $error("wheel indicator wrong");
  chk_spare_dark: assert property (!spare_indicator)
    else $error("spare indicator lit");
  chk_ack_pulls_low: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  chk_trip_forces_off: assert property (watchdog_tripped |-> !(wheel_heater_on || bench_element_low_on ||
    bench_element_high_on || sample_cal_valve_on || zero_span_valve_on || shutoff_valve_on || ir_source_on))
    else $error("output on while tripped");
  chk_flip_clears_trip: assert property (hb_flip |=> !watchdog_tripped [*4])
    else $error("trip kept after heartbeat change");
  chk_trip_not_early: assert property ($rose(watchdog_tripped) |-> quiet_ff >= WD_LIMIT)
    else $error("watchdog tripped early");
  chk_trip_not_late: assert property (quiet_ff == WD_LIMIT + 2 |-> watchdog_tripped)
    else $error("watchdog failed to trip");
endmodule : relay_watchdog_monitor

// *** sim/i2c_host_model.sv ***
// Host side of the I2C link: START, address, one command byte, STOP.
// SCL idles high between frames; SDA has a pull-up, so a released line reads 1.
`timescale 1ns/10ps
module i2c_host_model (
  output logic scl_i,
  output logic sda_i,
  input wire logic sda_oe
);
  logic sda_drv = 1'b1;
  initial scl_i = 1'b1;
  assign sda_i = sda_drv & ~sda_oe;
  // Eight bits then the acknowledge slot; 800 ns per bit
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #100 sda_drv = (i < 0) ? 1'b1 : b[i];
      #300 scl_i = 1'b1;
      #200 ack = ~sda_i;
      #200 scl_i = 1'b0;
    end
  endtask : put
  task automatic write(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic a1, a2;
    sda_drv = 1'b0;
    #400 scl_i = 1'b0;
    put(a, a1);
    put(d, a2);
    #100 sda_drv = 1'b0;
    #300 scl_i = 1'b1;
    #300 sda_drv = 1'b1;
    #400 ack = a1 & a2;
  endtask : write
endmodule : i2c_host_model

// *** sim/relay_watchdog_tb_top.sv ***
// Bench for the relay board control: commands, strap codes, refused frames, watchdog.
// Assumes the host model on the I2C pins; watchdog limit shortened to WDL cycles.
`timescale 1ns/10ps
module relay_watchdog_tb_top import relay_pkg::*;;
  localparam int unsigned WDL = 2000;
  logic mclk, nrst, ack;
  logic [1:0] line_volt_sel;
  wire scl, sda;
  logic sda_oe, wheel_heater_on, bench_element_low_on, bench_element_high_on, motor_supply_on;
  logic sample_cal_valve_on, zero_span_valve_on, shutoff_valve_on, ir_source_on, watchdog_tripped;
  logic heartbeat_indicator, wheel_heat_indicator, bench_heat_indicator, spare_indicator;
  logic sample_cal_valve_indicator, zero_span_valve_indicator, shutoff_valve_indicator, ir_source_indicator;
  int num_errors = 0, checks = 0, cyc = 0;
  wire [16:0] obs = {watchdog_tripped, motor_supply_on, heartbeat_indicator, spare_indicator, ir_source_on,
    ir_source_indicator, wheel_heater_on, wheel_heat_indicator, bench_element_low_on, bench_element_high_on,
    bench_heat_indicator, sample_cal_valve_on, sample_cal_valve_indicator, zero_span_valve_on,
    zero_span_valve_indicator, shutoff_valve_on, shutoff_valve_indicator};
  relay_watchdog #(.WD_LIMIT(WDL)) u_relay_watchdog (.mclk, .nrst, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe,
    .line_volt_sel, .wheel_heater_on, .bench_element_low_on, .bench_element_high_on, .motor_supply_on,
    .sample_cal_valve_on, .zero_span_valve_on, .shutoff_valve_on, .ir_source_on, .watchdog_tripped,
    .heartbeat_indicator, .wheel_heat_indicator, .bench_heat_indicator, .spare_indicator,
    .sample_cal_valve_indicator, .zero_span_valve_indicator, .shutoff_valve_indicator, .ir_source_indicator);
  i2c_host_model u_i2c_host_model (.scl_i(scl), .sda_i(sda), .sda_oe);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [16:0] exp_out(logic [7:0] c, logic [1:0] l, logic t);
    logic b, h;
    b = c[CMD_BENCH_HEAT] & ~t;
    h = (l == LINE_230);
    return {t, 1'b1, c[CMD_HEARTBEAT], 1'b0, {2{~c[CMD_IR_OFF] & ~t}}, {2{c[CMD_WHEEL_HEAT] & ~t}},
      b & ~h, b & h, b, {2{c[CMD_SAMPLE_CAL] & ~t}}, {2{c[CMD_ZERO_SPAN] & ~t}},
      {2{c[CMD_SHUTOFF] & ~t}}};
  endfunction : exp_out
  task automatic check(string n, logic [16:0] got, logic [16:0] e);
    checks++;
    if (got !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, got);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic t_reset;
    repeat (2) @(negedge mclk);
    check("reset", obs, exp_out(CMD_RESET, line_volt_sel, 1'b0));
  endtask : t_reset
  task automatic t_cmds;
    // Bit 0 alternates so each write is also a heartbeat toggle
    logic [7:0] tbl [8] = '{8'h7f, 8'h24, 8'h55, 8'h0e, 8'h41, 8'h00, 8'h39, 8'h08};
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk) line_volt_sel <= 2'(i);
      // Link pins then move on falling edges only, so the synchroniser never races them
      @(negedge mclk);
      u_i2c_host_model.write({DEV_ADDR, 1'b0}, tbl[i], ack);
      repeat (4) @(negedge mclk);
      check("ack", 17'(ack), 17'h1);
      check("outputs", obs, exp_out(tbl[i], line_volt_sel, 1'b0));
    end
  endtask : t_cmds
  task automatic t_refuse;
    u_i2c_host_model.write({DEV_ADDR ^ 7'h01, 1'b0}, 8'h7f, ack);
    check("nak_addr", 17'(ack), 17'h0);
    u_i2c_host_model.write({DEV_ADDR, 1'b1}, 8'h7f, ack);
    check("nak_read", 17'(ack), 17'h0);
    check("kept", obs, exp_out(8'h08, line_volt_sel, 1'b0));
  endtask : t_refuse
  task automatic t_dog;
    u_i2c_host_model.write({DEV_ADDR, 1'b0}, 8'h75, ack);
    repeat (WDL - 40) @(negedge mclk);
    check("live", obs, exp_out(8'h75, line_volt_sel, 1'b0));
    repeat (60) @(negedge mclk);
    check("trip", obs, exp_out(8'h75, line_volt_sel, 1'b1));
    u_i2c_host_model.write({DEV_ADDR, 1'b0}, 8'h74, ack);
    repeat (4) @(negedge mclk);
    check("clear", obs, exp_out(8'h74, line_volt_sel, 1'b0));
  endtask : t_dog
  task automatic t_rst_mid;
    @(posedge mclk) nrst <= 1'b0;
    repeat (2) @(negedge mclk);
    check("in_reset", obs, 17'h0);
    @(posedge mclk) nrst <= 1'b1;
    repeat (2) @(negedge mclk);
    check("after_reset", obs, exp_out(CMD_RESET, line_volt_sel, 1'b0));
  endtask : t_rst_mid
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    nrst = 1'b0;
    line_volt_sel = LINE_100;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_cmds();
    t_refuse();
    t_dog();
    t_rst_mid();
    summarize();
  end
endmodule : relay_watchdog_tb_top
bind relay_watchdog relay_watchdog_monitor #(.WD_LIMIT(WD_LIMIT)) u_relay_watchdog_monitor (.mclk, .nrst,
  .wheel_heater_on, .bench_element_low_on, .bench_element_high_on, .motor_supply_on, .sample_cal_valve_on,
  .zero_span_valve_on, .shutoff_valve_on, .ir_source_on, .watchdog_tripped, .heartbeat_indicator,
  .wheel_heat_indicator, .bench_heat_indicator, .spare_indicator, .sda_o, .sda_oe);
